// file: core/tof_pkg.sv
`default_nettype none
package tof_pkg;
    // Logic clock
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Offline short diagnostic, per step
    localparam int unsigned SHT_TIME_NS = 2000000;
    localparam int unsigned SHT_CYC = (SHT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Passive open-load test time, both steps together (plain default)
    localparam int unsigned OL_TIME_NS = 2000000;
    localparam int unsigned OL_CYC = (OL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    localparam int NPH = 3;
    localparam int NDRV = 6;
    localparam int NSYNC = 24;
    // Register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    // Control fields
    localparam int CTRL_REP_BIT = 0;
    localparam int CTRL_RECOV_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_CLR_BIT = 3;
    localparam logic RECOV_RST = 1'b0;
    localparam logic REP_RST = 1'b0;
    // Status fields
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_WARN_BIT = 1;
    localparam int ST_THERMAL_SHUTDOWN_FLAG_BIT = 2;
    localparam int ST_OLSHT_BIT = 3;
    localparam int ST_OPEN_LSB = 4;
    localparam int ST_SSUP_LSB = 7;
    localparam int ST_SGND_LSB = 10;
    localparam int ST_PUV_BIT = 13;
    localparam int ST_BUSY_BIT = 14;
    localparam int ST_GATE_BIT = 15;
    // Diagnostic sequencer, Gray codes from IDLE to OPD; returns to IDLE from SGND or OPD flip two bits
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SSUP = 3'h1,
        ST_SGND = 3'h3,
        ST_OPU = 3'h2,
        ST_OPD = 3'h6
    } tof_state_t;
endpackage : tof_pkg
`default_nettype wire

// file: core/tof_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Raw asynchronous levels in, filtered levels out
interface tof_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;   // Straight from the pins
    logic [W-1:0] clean; // Settled copy on CLK
    modport user (output raw, input clean);
    modport sync (input raw, output clean);
endinterface : tof_sync_if
`default_nettype wire

// file: core/tof_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tof_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    tof_sync_if.sync sif
);
    logic [W-1:0] s1_ff; // Metastability catcher, read only by s2
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] clean_ff;

    initial begin
        if (W < 1) $error("tof_sync width must be at least one");
    end

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= sif.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Per bit agreement filter rejects single-cycle glitches
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            clean_ff <= '0;
        end else begin
            clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
        end
    end

    assign sif.clean = clean_ff;
endmodule : tof_sync
`default_nettype wire

// file: core/tof_fault_core.sv
`timescale 1ns/1ps
`default_nettype none
module tof_fault_core
    import tof_pkg::*;
#(
    parameter bit PIN_CONFIG = 1'b0,       // 1: pin-configured variant
    parameter int SHT_CYCLES = SHT_CYC,    // Each short step
    parameter int OL_CYCLES = OL_CYC       // Whole passive test
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLEEP_N,
    input wire logic ENABLE,
    input wire logic DIAG_DISABLE_N,
    input wire logic TEMP_WARN,
    input wire logic TEMP_SD,
    input wire logic PUMP_UV,
    input wire logic [2:0] PU_CMP,
    input wire logic [2:0] PD_CMP,
    input wire logic [2:0] SHT_SUP_CMP,
    input wire logic [2:0] SHORT_GROUND_TEST_CMP,
    input wire logic [5:0] DRIVE_IN,
    output logic GATE_EN,
    output logic PUMP_EN,
    output logic [2:0] PULLUP_EN,
    output logic [2:0] PULLDOWN_EN,
    output logic FAULT_N_O,
    output logic FAULT_N_OE
);
    initial begin
        if (SHT_CYCLES < 2 || SHT_CYCLES >= (1 << TMR_W)) $error("SHT_CYCLES out of range");
        if (OL_CYCLES < 4 || OL_CYCLES >= (1 << TMR_W)) $error("OL_CYCLES out of range");
    end

    // Step lengths loaded into the down counter
    localparam logic [TMR_W-1:0] SHT_LOAD = TMR_W'(SHT_CYCLES - 1);
    localparam logic [TMR_W-1:0] OLH_LOAD = TMR_W'(OL_CYCLES / 2 - 1);

    // Synchronised pin levels
    tof_sync_if #(.W(NSYNC)) sif ();
    logic sleep_n_s, en_s, diag_dis_n_s, twarn_s, tsd_s, puv_s;
    logic [2:0] pu_s, pd_s, ssup_s, sgnd_s;
    logic [5:0] drv_s;

    assign sif.raw = {DRIVE_IN, SHORT_GROUND_TEST_CMP, SHT_SUP_CMP, PD_CMP, PU_CMP,
                      PUMP_UV, TEMP_SD, TEMP_WARN, DIAG_DISABLE_N, ENABLE, SLEEP_N};
    // Every analog comparator and pin goes through the filter first
    tof_sync #(.W(NSYNC)) u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .sif(sif)
    );
    assign {drv_s, sgnd_s, ssup_s, pd_s, pu_s, puv_s, tsd_s, twarn_s,
            diag_dis_n_s, en_s, sleep_n_s} = sif.clean;

    // Registers and state
    logic rep_ff;             // warn_report_enable
    logic recov_ff;           // shutdown_recovery_select
    logic start_ff;           // passive_openload_start
    logic warn_ff;            // thermal_warn_flag
    logic thermal_shutdown_flag_flag_ff;       // thermal_shutdown_flag
    logic thermal_shutdown_flag_stop_ff;       // Drive and pump held off by heat
    logic fault_ff;           // Fault summary
    logic olsht_ff;           // openload_short_summary
    logic puv_flag_ff;        // pump_undervoltage_flag
    logic [2:0] open_ff;      // phase_open_flag_x
    logic [2:0] ssup_ff;      // Short to supply per phase
    logic [2:0] sgnd_ff;      // Short to ground per phase
    logic [2:0] pu_open_ff;   // Pullup step result
    logic cmd_run_ff;         // Test launched by software
    logic pend_ff;            // Power-up or wake diagnostic owed
    logic sleep_prev_ff;
    logic [5:0] drv_prev_ff;
    logic [TMR_W-1:0] tmr_ff;
    tof_state_t state_ff, nxt_state;
    logic gate_ff, pump_ff, fault_low_ff;
    logic [2:0] pu_en_ff, pd_en_ff;
    logic [31:0] rdata_ff;

    // Bus decode; zero wait states
    logic wr_ctrl, acc, mapped;
    assign acc = PSEL & PENABLE;
    assign mapped = (PADDR == CTRL_OFS) || (PADDR == STAT_OFS);
    assign wr_ctrl = acc & PWRITE & (PADDR == CTRL_OFS);
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;
    assign PRDATA = rdata_ff;

    // Clear sources: command write, sleep pulse, enable pulse
    logic clr_cmd, clr_all, clr_diag, recov_auto;
    assign clr_cmd = wr_ctrl & PWDATA[CTRL_CLR_BIT];
    assign clr_all = clr_cmd | ~sleep_n_s;
    assign clr_diag = clr_all | ~en_s;
    // Pin variant has no select bit and always recovers by itself
    assign recov_auto = PIN_CONFIG ? 1'b1 : recov_ff;

    // Sequencer events
    logic busy, step_done, drv_chg, abort, cmd_go, auto_go, auto_skip;
    logic [2:0] open_hit;
    assign busy = (state_ff != ST_IDLE);
    assign step_done = (tmr_ff == '0);
    assign drv_chg = (drv_s != drv_prev_ff);
    // Any drive input change, start cleared, sleep or disable stops the test quietly
    assign abort = busy & (drv_chg | (cmd_run_ff & ~start_ff) | ~sleep_n_s | ~en_s);
    assign cmd_go = ~PIN_CONFIG & ~busy & start_ff & sleep_n_s & en_s;
    assign auto_go = PIN_CONFIG & ~busy & pend_ff & sleep_n_s & en_s & ~diag_dis_n_s;
    assign auto_skip = PIN_CONFIG & ~busy & pend_ff & sleep_n_s & en_s & diag_dis_n_s;
    // Open only when both the pullup and the pulldown steps tripped
    assign open_hit = pu_open_ff & pd_s;

    // Next sequencer state
    always_comb begin
        nxt_state = state_ff;
        if (abort) begin
            nxt_state = ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (auto_go) begin
                        nxt_state = ST_SSUP;
                    end else if (cmd_go) begin
                        nxt_state = ST_OPU;
                    end
                end
                ST_SSUP: begin
                    if (step_done) begin
                        // A short ends the sequence before open-load
                        nxt_state = (|ssup_s) ? ST_IDLE : ST_SGND;
                    end
                end
                ST_SGND: begin
                    if (step_done) begin
                        nxt_state = (|sgnd_s) ? ST_IDLE : ST_OPU;
                    end
                end
                ST_OPU: begin
                    if (step_done) begin
                        nxt_state = ST_OPD;
                    end
                end
                ST_OPD: begin
                    if (step_done) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE; // Unused codes
                end
            endcase
        end
    end

    // Sequencer state and step timer
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
            tmr_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff) begin
                tmr_ff <= (nxt_state == ST_SSUP || nxt_state == ST_SGND) ? SHT_LOAD : OLH_LOAD;
            end else if (!step_done) begin
                tmr_ff <= tmr_ff - 1'b1;
            end
        end
    end

    // Launch bookkeeping and input history
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_ff <= 1'b1; // Power-up owes one diagnostic pass
            cmd_run_ff <= 1'b0;
            sleep_prev_ff <= 1'b0;
            drv_prev_ff <= '0;
            pu_open_ff <= '0;
        end else begin
            sleep_prev_ff <= sleep_n_s;
            drv_prev_ff <= drv_s;
            if (sleep_n_s & ~sleep_prev_ff) begin
                pend_ff <= 1'b1; // Wake from sleep
            end else if (auto_go | auto_skip | ~PIN_CONFIG) begin
                pend_ff <= 1'b0; // Tied-high strap skips the whole pass
            end
            if (cmd_go) begin
                cmd_run_ff <= 1'b1;
            end else if (nxt_state == ST_IDLE) begin
                cmd_run_ff <= 1'b0;
            end
            if (state_ff == ST_OPU && step_done) begin
                pu_open_ff <= pu_s;
            end
        end
    end

    // Control register; select resets to latched recovery
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rep_ff <= REP_RST;
            recov_ff <= RECOV_RST;
            start_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                rep_ff <= PWDATA[CTRL_REP_BIT];
                recov_ff <= PWDATA[CTRL_RECOV_BIT];
                start_ff <= PWDATA[CTRL_START_BIT] & ~PIN_CONFIG;
            end else if (cmd_run_ff && (abort || (state_ff == ST_OPD && step_done))) begin
                // Written value stands until the test ends; an abort drops it too,
                // otherwise the idle sequencer would relaunch the test at once
                start_ff <= 1'b0;
            end
        end
    end

    // Warning flag follows the comparator except in the pin variant, which holds it low; its hysteresis is analog
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            warn_ff <= 1'b0;
        end else begin
            warn_ff <= twarn_s & ~PIN_CONFIG;
        end
    end

    // Thermal shutdown; no bit anywhere can mask tsd_s
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            thermal_shutdown_flag_stop_ff <= 1'b0;
            thermal_shutdown_flag_flag_ff <= 1'b0;
        end else begin
            thermal_shutdown_flag_flag_ff <= tsd_s | (thermal_shutdown_flag_flag_ff & ~clr_all);
            if (tsd_s) begin
                thermal_shutdown_flag_stop_ff <= 1'b1;
            end else if (recov_auto) begin
                thermal_shutdown_flag_stop_ff <= 1'b0;
            end else if (clr_all) begin
                thermal_shutdown_flag_stop_ff <= 1'b0;
            end
        end
    end

    // Pump undervoltage only counts while the pump is meant to run
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            puv_flag_ff <= 1'b0;
        end else begin
            puv_flag_ff <= (puv_s & pump_ff) | (puv_flag_ff & ~clr_diag);
        end
    end

    // Diagnostic result flags; a set beats a clear in the same cycle
    logic ol_set, ssup_set, sgnd_set;
    assign ol_set = (state_ff == ST_OPD) & step_done & ~abort;
    assign ssup_set = (state_ff == ST_SSUP) & step_done & ~abort;
    assign sgnd_set = (state_ff == ST_SGND) & step_done & ~abort;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            open_ff <= '0;
            ssup_ff <= '0;
            sgnd_ff <= '0;
        end else begin
            open_ff <= ({3{ol_set}} & open_hit) | (open_ff & ~{3{clr_diag}});
            ssup_ff <= ({3{ssup_set}} & ssup_s) | (ssup_ff & ~{3{clr_diag}});
            sgnd_ff <= ({3{sgnd_set}} & sgnd_s) | (sgnd_ff & ~{3{clr_diag}});
        end
    end

    // Summaries
    logic diag_new, diag_hold;
    assign diag_new = (ol_set & (|open_hit)) | (ssup_set & (|ssup_s)) | (sgnd_set & (|sgnd_s));
    assign diag_hold = (|open_ff) | (|ssup_ff) | (|sgnd_ff);
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            olsht_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            olsht_ff <= diag_new | (olsht_ff & ~clr_diag);
            fault_ff <= tsd_s | diag_new | (puv_s & pump_ff) | (fault_ff & ~clr_diag);
        end
    end

    // Drive permission, pump and current sources from next-state terms
    logic nxt_stop, nxt_busy;
    assign nxt_stop = tsd_s | (thermal_shutdown_flag_stop_ff & ~(recov_auto | clr_all));
    assign nxt_busy = (nxt_state != ST_IDLE);
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gate_ff <= 1'b0;
            pump_ff <= 1'b0;
            pu_en_ff <= '0;
            pd_en_ff <= '0;
        end else begin
            // Latched diagnostic faults block drive until cleared
            gate_ff <= sleep_n_s & en_s & ~nxt_stop & ~nxt_busy & ~diag_hold & ~diag_new;
            pump_ff <= sleep_n_s & ~nxt_stop;
            pu_en_ff <= {3{nxt_state == ST_SGND || nxt_state == ST_OPU}};
            pd_en_ff <= {3{nxt_state == ST_SSUP || nxt_state == ST_OPD}};
        end
    end

    // Fault pin pulled low for shutdown, diagnostics or reported warning
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fault_low_ff <= 1'b0;
        end else begin
            fault_low_ff <= nxt_stop | diag_hold | diag_new | (warn_ff & rep_ff);
        end
    end

    // Read data captured in setup so it is stable through the access
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_ff <= '0;
        end else if (PSEL && !PENABLE) begin
            rdata_ff <= '0;
            if (PADDR == CTRL_OFS) begin
                rdata_ff[CTRL_REP_BIT] <= rep_ff;
                rdata_ff[CTRL_RECOV_BIT] <= recov_auto;
                rdata_ff[CTRL_START_BIT] <= start_ff;
            end else if (PADDR == STAT_OFS) begin
                rdata_ff[ST_FAULT_BIT] <= fault_ff;
                rdata_ff[ST_WARN_BIT] <= warn_ff;
                rdata_ff[ST_THERMAL_SHUTDOWN_FLAG_BIT] <= thermal_shutdown_flag_flag_ff;
                rdata_ff[ST_OLSHT_BIT] <= olsht_ff;
                rdata_ff[ST_OPEN_LSB +: NPH] <= open_ff;
                rdata_ff[ST_SSUP_LSB +: NPH] <= ssup_ff;
                rdata_ff[ST_SGND_LSB +: NPH] <= sgnd_ff;
                rdata_ff[ST_PUV_BIT] <= puv_flag_ff;
                rdata_ff[ST_BUSY_BIT] <= busy;
                rdata_ff[ST_GATE_BIT] <= gate_ff;
            end
        end
    end

    assign GATE_EN = gate_ff;
    assign PUMP_EN = pump_ff;
    assign PULLUP_EN = pu_en_ff;
    assign PULLDOWN_EN = pd_en_ff;
    assign FAULT_N_O = 1'b0; // Open drain: only ever pulls low
    assign FAULT_N_OE = fault_low_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_warn_sets: assert property (
        (twarn_s && !PIN_CONFIG) |=> warn_ff ##0 (gate_ff || !$past(gate_ff) || $past(tsd_s)
            || $past(busy) || !sleep_n_s || !en_s || $past(diag_hold) || $past(nxt_busy)
            || !$past(sleep_n_s) || !$past(en_s) || $past(thermal_shutdown_flag_stop_ff)))
        else $error("warning did not set flag or disturbed drive");
    chk_warn_clears: assert property (
        !twarn_s |=> !warn_ff)
        else $error("warning flag stayed after cooling");
    chk_warn_report: assert property (
        (warn_ff && rep_ff) |=> FAULT_N_OE)
        else $error("reported warning not on fault pin");
    chk_tsd_action: assert property (
        tsd_s |=> (!GATE_EN && !PUMP_EN && FAULT_N_OE && thermal_shutdown_flag_flag_ff && fault_ff))
        else $error("shutdown response incomplete");
    chk_latched_hold: assert property (
        (thermal_shutdown_flag_stop_ff && !recov_auto && !clr_all) |=> (!GATE_EN && FAULT_N_OE))
        else $error("latched shutdown released without clear");
    chk_pump_no_uv: assert property (
        !pump_ff |=> !$rose(puv_flag_ff))
        else $error("pump stop raised undervoltage flag");
    chk_test_gates_off: assert property (
        busy |-> !GATE_EN)
        else $error("gates enabled during diagnostic");
    chk_abort_quiet: assert property (
        (busy && drv_chg) |=> (state_ff == ST_IDLE) && $stable(open_ff) && $stable(olsht_ff))
        else $error("abort did not end the test quietly");
endmodule : tof_fault_core
`default_nettype wire

// file: sim/tof_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller model: APB master plus the sleep, enable and drive pins
module tof_mcu_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic sleep_n,
    output logic enable,
    output logic [5:0] drive_in
);
    // Bus idle, device awake and enabled, all bridges parked off
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleep_n = 1'b1;
        enable = 1'b1;
        drive_in = 6'h00;
    end
    // One transfer; request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No cycle count assumed; the bench watchdog bounds this
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : tof_mcu_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tof_pkg::*;
    // Status words built from the field positions
    localparam logic [31:0] G = 32'h1 << ST_GATE_BIT;
    localparam logic [31:0] F = 32'h1 << ST_FAULT_BIT;
    localparam logic [31:0] T = 32'h1 << ST_THERMAL_SHUTDOWN_FLAG_BIT;
    localparam logic [31:0] O = 32'h1 << ST_OLSHT_BIT;
    typedef struct packed {logic warn; logic rep; logic [31:0] st; logic oe;} tof_row_t;
    tof_row_t rows [4]; // Warning cases: inputs beside expected results
    logic clk, sys_rst, temp_warn, temp_sd, pump_uv;
    logic [2:0] pu_cmp, pd_cmp, pu_en, pd_en;
    logic psel, penable, pwrite, pready, pslverr, sleep_n, enable;
    logic gate_en, pump_en, fault_o, fault_oe, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0] drive_in;
    int n_errors, comparisons;
    // Short and open-load tests shortened so the run stays brief
    tof_fault_core #(.SHT_CYCLES(8), .OL_CYCLES(8)) DUT (
        .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SLEEP_N(sleep_n), .ENABLE(enable),
        .DIAG_DISABLE_N(1'b0), .TEMP_WARN(temp_warn), .TEMP_SD(temp_sd),
        .PUMP_UV(pump_uv), .PU_CMP(pu_cmp), .PD_CMP(pd_cmp), .SHT_SUP_CMP(3'h0),
        .SHORT_GROUND_TEST_CMP(3'h0), .DRIVE_IN(drive_in), .GATE_EN(gate_en), .PUMP_EN(pump_en),
        .PULLUP_EN(pu_en), .PULLDOWN_EN(pd_en), .FAULT_N_O(fault_o), .FAULT_N_OE(fault_oe));
    tof_mcu_model mcu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_n(sleep_n), .enable(enable), .drive_in(drive_in));
    // 25 MHz clock
    always #20 clk = ~clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mcu.xfer(1'b1, a, d, q, e);
    endtask : wr
    // Read status and compare whole word
    task automatic st(input logic [31:0] exp);
        mcu.xfer(1'b0, STAT_OFS, 32'h0, q, e);
        check(q, exp);
    endtask : st
    task automatic ctl(input logic [31:0] exp);
        mcu.xfer(1'b0, CTRL_OFS, 32'h0, q, e);
        check(q, exp);
    endtask : ctl
    // Pins as {pump, gate, fault pulled low}
    task automatic pins(input logic [2:0] exp);
        check({29'h0, pump_en, gate_en, fault_oe}, {29'h0, exp});
    endtask : pins
    // Wait, then step past the edge so registered outputs have settled
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cy
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        temp_warn = 1'b0;
        temp_sd = 1'b0;
        pump_uv = 1'b0;
        pu_cmp = 3'h0;
        pd_cmp = 3'h0;
        rows[0] = '{1'b0, 1'b0, G, 1'b0};
        rows[1] = '{1'b1, 1'b0, G | (32'h1 << ST_WARN_BIT), 1'b0};
        rows[2] = '{1'b1, 1'b1, G | (32'h1 << ST_WARN_BIT), 1'b1};
        rows[3] = '{1'b0, 1'b1, G, 1'b0};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        cy(10);
        ctl(32'h0);
        pins(3'b110);
        // Warning table; summary bit masked, every other status bit judged
        foreach (rows[i]) begin
            @(posedge clk) temp_warn <= rows[i].warn;
            wr(CTRL_OFS, {31'h0, rows[i].rep});
            cy(10);
            mcu.xfer(1'b0, STAT_OFS, 32'h0, q, e);
            check(q & 32'hfffe, rows[i].st);
            check({31'h0, fault_oe}, {31'h0, rows[i].oe});
        end
        // Latched shutdown: cooling alone must not release
        @(posedge clk) temp_sd <= 1'b1;
        cy(10);
        pins(3'b001);
        // Undervoltage while the pump is stopped by heat must not flag
        @(posedge clk) pump_uv <= 1'b1;
        cy(10);
        st(F | T);
        @(posedge clk) temp_sd <= 1'b0;
        pump_uv <= 1'b0;
        cy(10);
        pins(3'b001);
        wr(CTRL_OFS, 32'h8);
        cy(10);
        pins(3'b110);
        st(G);
        // Automatic recovery: drive resumes, flag stays until cleared
        wr(CTRL_OFS, 32'h2);
        ctl(32'h2);
        @(posedge clk) temp_sd <= 1'b1;
        cy(10);
        pins(3'b001);
        @(posedge clk) temp_sd <= 1'b0;
        cy(10);
        pins(3'b110);
        mcu.xfer(1'b0, STAT_OFS, 32'h0, q, e);
        check(q & T, T);
        wr(CTRL_OFS, 32'ha);
        cy(5);
        st(G);
        // Passive test finding an open load on phase 2 only
        @(posedge clk) pu_cmp <= 3'b101;
        pd_cmp <= 3'b100;
        cy(10);
        wr(CTRL_OFS, 32'h4);
        ctl(32'h4);
        cy(1);
        check({28'h0, gate_en, pu_en}, {28'h0, 1'b0, 3'h7});
        cy(3);
        check({29'h0, pd_en}, 32'h7);
        cy(15);
        st(F | O | (32'h4 << ST_OPEN_LSB));
        pins(3'b101);
        ctl(32'h0);
        // Enable pulse clears the open-load fault
        @(posedge clk) mcu.enable <= 1'b0;
        cy(10);
        @(posedge clk) mcu.enable <= 1'b1;
        cy(15);
        st(G);
        pins(3'b110);
        // Same fault, cleared by a sleep pulse
        wr(CTRL_OFS, 32'h4);
        cy(20);
        pins(3'b101);
        @(posedge clk) mcu.sleep_n <= 1'b0;
        cy(10);
        @(posedge clk) mcu.sleep_n <= 1'b1;
        cy(15);
        st(G);
        // No open load: start bit drops, nothing reported
        @(posedge clk) pu_cmp <= 3'h0;
        pd_cmp <= 3'h0;
        cy(5);
        wr(CTRL_OFS, 32'h4);
        cy(20);
        ctl(32'h0);
        st(G);
        // Aborts with every phase open: any stray result would show
        @(posedge clk) pu_cmp <= 3'h7;
        pd_cmp <= 3'h7;
        cy(5);
        wr(CTRL_OFS, 32'h4);
        cy(1);
        @(posedge clk) mcu.drive_in <= 6'h01;
        cy(15);
        st(G);
        ctl(32'h0);
        wr(CTRL_OFS, 32'h4);
        cy(2);
        wr(CTRL_OFS, 32'h0);
        cy(15);
        st(G);
        pins(3'b110);
        // Undervoltage with the pump running latches flag and summary
        @(posedge clk) pump_uv <= 1'b1;
        cy(10);
        @(posedge clk) pump_uv <= 1'b0;
        st(G | F | (32'h1 << ST_PUV_BIT));
        wr(CTRL_OFS, 32'h8);
        st(G);
        // Unmapped read errors; status ignores writes
        mcu.xfer(1'b0, 12'h008, 32'h0, q, e);
        check(q, 32'h0);
        check({31'h0, e}, 32'h1);
        check({31'h0, fault_o}, 32'h0);
        wr(STAT_OFS, 32'hffff);
        st(G);
        stop_test();
    end
endmodule : tb
`default_nettype wire
